// ### pkg/power_sequencer_consts.svh
`ifndef POWER_SEQUENCER_CONSTS_SVH
`define POWER_SEQUENCER_CONSTS_SVH
`define EN_CLEAR_DELAY 3
`define STEP_COUNT 6
`define STEP_CYCLES 4
`define HW_TRIG_LSB 7
`define HW_TRIG_MSB 11
`define HW_TRIG_W 5
`define STATE_W 3
`define STATE_IDLE 3'h0
`define STATE_START 3'h1
`define STATE_STEP 3'h2
`define STATE_GATE 3'h3
`define STATE_DONE 3'h4
`endif

// ### pkg/power_sequencer_pkg.sv
package power_sequencer_pkg;
  typedef enum {SQ_IDLE, SQ_START, SQ_STEP, SQ_GATE, SQ_DONE} seq_state_t;
  typedef enum logic {SEQ_A = 1'b0, SEQ_B = 1'b1} seq_kind_t;
endpackage

// ### pkg/gating_if.sv
`timescale 1ns/1ns
`default_nettype none
interface gating_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport gate (input start, output busy, output done);
endinterface
`default_nettype wire

// ### core/gating_controller.sv
`timescale 1ns/1ns
`default_nettype none
// waits for components with no time-out by design
module gating_controller (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic components_ready,
  gating_if.gate gif
);
  logic busy_q, busy_d;
  logic done_q, done_d;
  always_comb begin
    busy_d = busy_q;
    done_d = 1'b0;
    if (!busy_q && gif.start) begin
      busy_d = 1'b1;
    end else if (busy_q && components_ready) begin
      busy_d = 1'b0;
      done_d = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end
  assign gif.busy = busy_q;
  assign gif.done = done_q;
  a_gate_done_cause: assert property (@(posedge ref_clk)
    disable iff (rst) gif.done |-> $past(busy_q) && $past(components_ready))
    else $error("gating done without ready component");
endmodule
`default_nettype wire

// ### core/power_transition_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "power_sequencer_consts.svh"
module power_transition_sequencer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic set_a_enable,
  input wire logic set_b_enable,
  input wire logic set_a_trigger,
  input wire logic b_sequence_trigger,
  input wire logic [`HW_TRIG_W-1:0] b_hw_trigger_enable,
  input wire logic [`HW_TRIG_W-1:0] b_hw_trigger_src,
  input wire logic gating_bypass,
  input wire logic [`STEP_COUNT-1:0] step_copy_enable,
  input wire logic components_ready,
  output logic a_sequence_enable,
  output logic b_sequence_enable,
  output logic [`STATE_W-1:0] sequencer_state,
  output logic last_sequence_flag,
  output logic gating_status,
  output logic [`STEP_COUNT-1:0] step_apply
);
  import power_sequencer_pkg::*;
  gating_if gif ();
  gating_controller u_gate (
    .ref_clk(ref_clk),
    .rst(rst),
    .components_ready(components_ready),
    .gif(gif)
  );
  logic [`HW_TRIG_W-1:0] hw_s1_q, hw_s2_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hw_s1_q <= '0;
      hw_s2_q <= '0;
    end else begin
      hw_s1_q <= b_hw_trigger_src;
      hw_s2_q <= hw_s1_q;
    end
  end
  seq_state_t st_q, st_d;
  seq_kind_t kind_q, kind_d;
  logic a_en_q, a_en_d, b_en_q, b_en_d;
  logic a_done_q, a_done_d;  // interlock: A finished since last B
  logic last_q, last_d;
  logic [1:0] clr_cnt_q, clr_cnt_d;
  logic [2:0] step_q, step_d;
  logic [1:0] dwell_q, dwell_d;
  logic [`STEP_COUNT-1:0] apply_q, apply_d;
  logic gate_start;
  logic [`STATE_W-1:0] state_code_q, state_code_d;
  logic hw_b;
  logic start_a, start_b;
  assign hw_b = |(hw_s2_q & b_hw_trigger_enable);
  // triggers only count with the enable already set, so a same-write pair
  // cannot start anything
  assign start_a = set_a_trigger && a_en_q;
  assign start_b = (b_sequence_trigger || hw_b) && b_en_q && a_done_q;
  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    a_en_d = a_en_q || set_a_enable;
    b_en_d = b_en_q || set_b_enable;
    a_done_d = a_done_q;
    last_d = last_q;
    clr_cnt_d = clr_cnt_q;
    step_d = step_q;
    dwell_d = dwell_q;
    apply_d = '0;
    gate_start = 1'b0;
    case (st_q)
      SQ_IDLE: begin
        if (start_a) begin
          st_d = SQ_START;
          kind_d = SEQ_A;
          clr_cnt_d = 2'd1;
        end else if (start_b) begin
          st_d = SQ_START;
          kind_d = SEQ_B;
          clr_cnt_d = 2'd1;
        end
      end
      SQ_START: begin
        if (clr_cnt_q == 2'(`EN_CLEAR_DELAY - 1)) begin
          if (kind_q == SEQ_A) begin
            a_en_d = 1'b0;
          end else begin
            b_en_d = 1'b0;
          end
          st_d = SQ_STEP;
          step_d = 3'd0;
          dwell_d = 2'd0;
        end else begin
          clr_cnt_d = clr_cnt_q + 2'd1;
        end
      end
      SQ_STEP: begin
        if (dwell_q == 2'(`STEP_CYCLES - 1)) begin
          dwell_d = 2'd0;
          if (kind_q == SEQ_B) begin
            apply_d[step_q] = step_copy_enable[step_q];
          end
          if (step_q == 3'(`STEP_COUNT - 1)) begin
            if (gating_bypass) begin
              st_d = SQ_DONE;
            end else begin
              gate_start = 1'b1;
              st_d = SQ_GATE;
            end
          end else begin
            step_d = step_q + 3'd1;
          end
        end else begin
          dwell_d = dwell_q + 2'd1;
        end
      end
      SQ_GATE: begin
        if (gif.done) begin
          st_d = SQ_DONE;
        end
      end
      SQ_DONE: begin
        st_d = SQ_IDLE;
        a_done_d = (kind_q == SEQ_A);
        last_d = (kind_q == SEQ_B);
      end
      default: st_d = SQ_IDLE;
    endcase
  end
  assign gif.start = gate_start;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= SQ_IDLE;
      kind_q <= SEQ_A;
      a_en_q <= 1'b0;
      b_en_q <= 1'b0;
      a_done_q <= 1'b0;
      last_q <= 1'b0;
      clr_cnt_q <= 2'd0;
      step_q <= 3'd0;
      dwell_q <= 2'd0;
      apply_q <= '0;
      state_code_q <= `STATE_IDLE;
    end else begin
      st_q <= st_d;
      kind_q <= kind_d;
      a_en_q <= a_en_d;
      b_en_q <= b_en_d;
      a_done_q <= a_done_d;
      last_q <= last_d;
      clr_cnt_q <= clr_cnt_d;
      step_q <= step_d;
      dwell_q <= dwell_d;
      apply_q <= apply_d;
      state_code_q <= state_code_d;
    end
  end
  always_comb begin
    case (st_d)
      SQ_IDLE: state_code_d = `STATE_IDLE;
      SQ_START: state_code_d = `STATE_START;
      SQ_STEP: state_code_d = `STATE_STEP;
      SQ_GATE: state_code_d = `STATE_GATE;
      SQ_DONE: state_code_d = `STATE_DONE;
      default: state_code_d = `STATE_IDLE;
    endcase
  end
  // state field comes from its own flop so software never reads a decode
  assign sequencer_state = state_code_q;
  assign a_sequence_enable = a_en_q;
  assign b_sequence_enable = b_en_q;
  assign last_sequence_flag = last_q;
  assign gating_status = gif.busy;
  assign step_apply = apply_q;

  sequence s_started;
    $rose(st_q == SQ_START);
  endsequence
  a_enable_clear_time: assert property (@(posedge ref_clk)
    disable iff (rst) s_started ##0 (kind_q == SEQ_A) |-> ##2 !a_en_q)
    else $error("A enable not cleared three cycles after start");
  a_b_enable_clear: assert property (@(posedge ref_clk)
    disable iff (rst) s_started ##0 (kind_q == SEQ_B) |-> ##2 !b_en_q)
    else $error("B enable not cleared three cycles after start");
  a_state_busy: assert property (@(posedge ref_clk)
    disable iff (rst) (st_q != SQ_IDLE && st_q != SQ_DONE)
      |=> sequencer_state != `STATE_IDLE)
    else $error("state field zero while flow runs");
  a_b_interlock: assert property (@(posedge ref_clk)
    disable iff (rst) s_started ##0 (kind_q == SEQ_B) |-> $past(a_done_q))
    else $error("B-sequence started without finished A");
  a_last_flag: assert property (@(posedge ref_clk)
    disable iff (rst)
      (st_q == SQ_DONE) |=> last_sequence_flag == (kind_q == SEQ_B))
    else $error("last-sequence flag wrong after completion");
  a_step_gated: assert property (@(posedge ref_clk)
    disable iff (rst) (|apply_q) |->
      (apply_q & ~$past(step_copy_enable)) == '0 && kind_q == SEQ_B)
    else $error("disabled step applied a change");
  a_bypass_skip: assert property (@(posedge ref_clk)
    disable iff (rst) gate_start |-> !gating_bypass)
    else $error("gating started while bypassed");
  a_hw_trig_off: assert property (@(posedge ref_clk)
    disable iff (rst) (st_q == SQ_IDLE && b_hw_trigger_enable == '0
      && !b_sequence_trigger && !set_a_trigger) |=> st_q == SQ_IDLE)
    else $error("hardware trigger ran while disabled");
  a_trig_ignored: assert property (@(posedge ref_clk)
    disable iff (rst) (st_q == SQ_IDLE && !a_en_q && !b_en_q)
      |=> st_q == SQ_IDLE)
    else $error("trigger with clear enable started a sequence");
  a_gate_wait: assert property (@(posedge ref_clk)
    disable iff (rst) (st_q == SQ_GATE && !gif.done) |=> st_q == SQ_GATE)
    else $error("sequence left gating stage early");
endmodule
`default_nettype wire

// ### tb/power_transition_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "power_sequencer_consts.svh"
module power_transition_sequencer_bench;
  logic ref_clk, rst, set_a_enable, set_b_enable, set_a_trigger;
  logic b_sequence_trigger, gating_bypass, components_ready;
  logic [`HW_TRIG_W-1:0] b_hw_trigger_enable, b_hw_trigger_src;
  logic [`STEP_COUNT-1:0] step_copy_enable, step_apply;
  logic a_sequence_enable, b_sequence_enable, last_sequence_flag;
  logic gating_status, gate_seen;
  logic [`STATE_W-1:0] sequencer_state;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int steps_seen;
  typedef struct {logic bypass; logic [5:0] mask; int steps;} row_t;
  row_t rows[4];

  power_transition_sequencer i_power_transition_sequencer (.ref_clk,
    .rst, .set_a_enable, .set_b_enable, .set_a_trigger, .b_sequence_trigger,
    .b_hw_trigger_enable, .b_hw_trigger_src, .gating_bypass,
    .step_copy_enable, .components_ready, .a_sequence_enable,
    .b_sequence_enable, .sequencer_state, .last_sequence_flag,
    .gating_status, .step_apply);

  initial begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end

  // the longest flow is well under 100 cycles; this leaves ample margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask

  // enable and trigger go in separate cycles, never together
  task automatic start(input logic b);
    if (b) set_b_enable = 1; else set_a_enable = 1;
    tick(1);
    set_a_enable = 0;
    set_b_enable = 0;
    if (b) b_sequence_trigger = 1; else set_a_trigger = 1;
    tick(1);
    set_a_trigger = 0;
    b_sequence_trigger = 0;
  endtask

  // checks enable once after a fixed wait, then polls the state field, bounded
  task automatic finish_seq(input logic b);
    chk("state busy", 32'(sequencer_state != 0), 1);
    tick(3);
    chk("enable cleared", b ? b_sequence_enable : a_sequence_enable, 0);
    steps_seen = 0;
    gate_seen = 0;
    for (int i = 0; i < 400 && sequencer_state !== 0; i++) begin
      steps_seen += $countones(step_apply);
      gate_seen |= gating_status;
      tick(1);
    end
    chk("state idle", sequencer_state, 0);
    chk("last flag", last_sequence_flag, b);
  endtask

  initial begin
    rst = 1;
    {set_a_enable, set_b_enable, set_a_trigger, b_sequence_trigger} = 0;
    b_hw_trigger_enable = 0;
    b_hw_trigger_src = 0;
    gating_bypass = 0;
    step_copy_enable = 0;
    components_ready = 1;
    rows[0] = '{1'b0, 6'h3f, 6};
    rows[1] = '{1'b1, 6'h00, 0};
    rows[2] = '{1'b0, 6'h21, 2};
    rows[3] = '{1'b1, 6'h0a, 2};
    tick(6);
    chk("state reset", sequencer_state, 0);
    chk("flag reset", last_sequence_flag, 0);
    rst = 0;
    tick(1);
    set_a_trigger = 1;
    tick(1);
    set_a_trigger = 0;
    tick(3);
    chk("bare trigger", sequencer_state, 0);
    foreach (rows[r]) begin
      // value sets change only while both enables are clear
      gating_bypass = rows[r].bypass;
      step_copy_enable = rows[r].mask;
      start(0);
      finish_seq(0);
      start(1);
      finish_seq(1);
      chk("steps applied", steps_seen, rows[r].steps);
      chk("gate used", gate_seen, !rows[r].bypass);
    end
    start(1);
    tick(4);
    chk("b interlocked", sequencer_state, 0);
    chk("b enable kept", b_sequence_enable, 1);
    start(0);
    finish_seq(0);
    b_hw_trigger_src = 5'h04;
    tick(8);
    chk("hw masked", sequencer_state, 0);
    b_hw_trigger_enable = 5'h04;
    for (int i = 0; i < 10 && sequencer_state === 0; i++) tick(1);
    finish_seq(1);
    b_hw_trigger_src = 0;
    b_hw_trigger_enable = 0;
    gating_bypass = 0;
    start(0);
    finish_seq(0);
    components_ready = 0;
    start(1);
    tick(60);
    chk("gate waits", sequencer_state, `STATE_GATE);
    chk("gate status", gating_status, 1);
    components_ready = 1;
    finish_seq(1);
    // reset in mid-flow must drop everything, then a fresh A must still run
    start(0);
    tick(1);
    rst = 1;
    tick(1);
    chk("reset mid flow", sequencer_state, 0);
    chk("reset enable", a_sequence_enable, 0);
    chk("reset flag", last_sequence_flag, 0);
    rst = 0;
    tick(2);
    chk("idle after reset", sequencer_state, 0);
    start(0);
    finish_seq(0);
    wrap_up();
  end
endmodule
`default_nettype wire
